/* design/fss_pkg.sv */
// constants and types for the fixed speed and jog setpoint selector
// Function
// - up to fifteen setpoints, selected from inputs or fieldbus
// - sixteen programmable setpoints, reset to zero rpm
// - setpoints one to three default to inputs 3-5
// - setpoint four source defaults zero, so unselected until configured
// - mode value 1 is direct, the reset default
// - direct mode outputs sum of selected setpoints
// - binary mode maps each non-zero combination to one setpoint
// - main source value 1024 routes fixed output
// - jog ignored while motor already switched on
// - jog runs motor while active, stops on release
// - two jog bits, sources default to zero
// - two jog speeds, each default 150 rpm
// - panel jog always accepted, inputs need routing
package fss_pkg;
	localparam int SP_W = 16;
	localparam int SUM_W = SP_W + 4;
	localparam int SP_COUNT = 16;
	localparam int SRC_W = 8;
	localparam int CFG_W = 16;
	typedef logic signed [SP_W-1:0] fss_speed_t;
	typedef logic signed [SUM_W-1:0] fss_sum_t;
	typedef logic [SRC_W-1:0] fss_src_t;
	// source code: zero, input status bit, fieldbus bit, constant one
	localparam fss_src_t SRC_ZERO = 8'h00;
	localparam fss_src_t SRC_INPUT_BASE = 8'h10;
	localparam fss_src_t SRC_BUS_BASE = 8'h20;
	localparam fss_src_t SRC_ONE = 8'hFF;
	localparam fss_src_t SRC_DEF_ONE = 8'h13;
	localparam fss_src_t SRC_DEF_TWO = 8'h14;
	localparam fss_src_t SRC_DEF_THREE = 8'h15;
	localparam fss_src_t SRC_DEF_FOUR = 8'h00;
	localparam fss_src_t SRC_DEF_JOG = 8'h00;
	localparam logic [1:0] MODE_DIRECT = 2'h1;
	localparam logic [1:0] MODE_BINARY = 2'h2;
	localparam logic [CFG_W-1:0] MAIN_SRC_FIXED = 16'h0400;
	localparam logic [CFG_W-1:0] MAIN_SRC_RESET = 16'h0000;
	localparam fss_speed_t SP_RESET = 16'h0000;
	localparam fss_speed_t JOG_SPEED_RESET = 16'h0096;
	// configuration write selectors
	localparam logic [3:0] CFG_SRC_ONE = 4'h0;
	localparam logic [3:0] CFG_SRC_TWO = 4'h1;
	localparam logic [3:0] CFG_SRC_THREE = 4'h2;
	localparam logic [3:0] CFG_SRC_FOUR = 4'h3;
	localparam logic [3:0] CFG_JOG0_SRC = 4'h4;
	localparam logic [3:0] CFG_JOG1_SRC = 4'h5;
	localparam logic [3:0] CFG_MODE = 4'h6;
	localparam logic [3:0] CFG_MAIN_SRC = 4'h7;
	localparam logic [3:0] CFG_JOG_SPEED_ONE = 4'h8;
	localparam logic [3:0] CFG_JOG_SPEED_TWO = 4'h9;
	typedef enum logic [1:0] {
		JOG_IDLE = 2'b01,
		JOG_RUN = 2'b10
	} fss_jog_e;
endpackage

/* design/fss_setpoint_select.sv */
// fixed speed and jog setpoint selector, top level
`timescale 1ns/1ps
`default_nettype none
module fss_setpoint_select import fss_pkg::*; (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic [15:0] DIGITAL_INPUT,
	input wire logic [15:0] FIELDBUS_WORD,
	input wire logic PANEL_JOG0,
	input wire logic PANEL_JOG1,
	input wire logic MOTOR_RUN,
	input wire logic CFG_WR_EN,
	input wire logic [3:0] CFG_WR_SEL,
	input wire logic [CFG_W-1:0] CFG_WR_DATA,
	input wire logic SP_WR_EN,
	input wire logic [3:0] SP_WR_IDX,
	input wire fss_speed_t SP_WR_DATA,
	output logic [15:0] DIGITAL_INPUT_STATUS,
	output logic [3:0] SELECT_ACTIVE,
	output fss_sum_t FIXED_SETPOINT_OUT,
	output fss_sum_t SPEED_SETPOINT,
	output logic MAIN_FROM_FIXED,
	output logic JOG_MOTOR_ON,
	output logic [1:0] JOG_ACTIVE_BITS
);
	fss_store_if sif ();

	fss_src_t src_reg [4];
	fss_src_t jog_src_reg [2];
	logic [1:0] fixed_select_mode_reg;
	logic [CFG_W-1:0] main_setpoint_source_reg;
	fss_speed_t jog_speed_one_reg;
	fss_speed_t jog_speed_two_reg;
	logic [15:0] input_status_reg;
	logic [3:0] sel;
	logic [1:0] jog_bits;
	logic jog_req;
	logic jog_req_reg;
	fss_jog_e jog_reg;
	fss_jog_e jog_next;
	fss_sum_t direct_sum;
	fss_sum_t fixed_next;
	fss_sum_t jog_speed_next;
	fss_sum_t speed_next;
	logic [3:0] fixed_out_dummy;

	function automatic fss_sum_t widen(input fss_speed_t v);
		widen = fss_sum_t'(v);
	endfunction

	fss_setpoint_store #(
		.DEPTH(SP_COUNT)
	) u_store (
		.clk(CLK),
		.reset_n(RESET_N),
		.sif(sif.store)
	);

	assign sif.wr_en = SP_WR_EN;
	assign sif.wr_idx = SP_WR_IDX;
	assign sif.wr_data = SP_WR_DATA;
	// binary code zero selects nothing, so code k reads entry k-1
	assign sif.rd_idx = sel - 4'h1;

	// configuration settings
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			src_reg[0] <= SRC_DEF_ONE;
			src_reg[1] <= SRC_DEF_TWO;
			src_reg[2] <= SRC_DEF_THREE;
			src_reg[3] <= SRC_DEF_FOUR;
			jog_src_reg[0] <= SRC_DEF_JOG;
			jog_src_reg[1] <= SRC_DEF_JOG;
			fixed_select_mode_reg <= MODE_DIRECT;
			main_setpoint_source_reg <= MAIN_SRC_RESET;
			jog_speed_one_reg <= JOG_SPEED_RESET;
			jog_speed_two_reg <= JOG_SPEED_RESET;
		end else if (CFG_WR_EN) begin
			unique case (CFG_WR_SEL)
				CFG_SRC_ONE: src_reg[0] <= CFG_WR_DATA[SRC_W-1:0];
				CFG_SRC_TWO: src_reg[1] <= CFG_WR_DATA[SRC_W-1:0];
				CFG_SRC_THREE: src_reg[2] <= CFG_WR_DATA[SRC_W-1:0];
				CFG_SRC_FOUR: src_reg[3] <= CFG_WR_DATA[SRC_W-1:0];
				CFG_JOG0_SRC: jog_src_reg[0] <= CFG_WR_DATA[SRC_W-1:0];
				CFG_JOG1_SRC: jog_src_reg[1] <= CFG_WR_DATA[SRC_W-1:0];
				CFG_MODE: fixed_select_mode_reg <= CFG_WR_DATA[1:0];
				CFG_MAIN_SRC: main_setpoint_source_reg <= CFG_WR_DATA;
				CFG_JOG_SPEED_ONE: jog_speed_one_reg <= fss_speed_t'(CFG_WR_DATA);
				CFG_JOG_SPEED_TWO: jog_speed_two_reg <= fss_speed_t'(CFG_WR_DATA);
				default: begin
				end
			endcase
		end
	end

	// input status is captured once so every selector sees the same sample
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			input_status_reg <= 16'h0000;
		end else begin
			input_status_reg <= DIGITAL_INPUT;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_sel
			fss_source_mux u_sel_mux (
				.src(src_reg[g]),
				.in_status(input_status_reg),
				.bus_word(FIELDBUS_WORD),
				.bit_out(sel[g])
			);
		end
		for (g = 0; g < 2; g++) begin : g_jog
			fss_source_mux u_jog_mux (
				.src(jog_src_reg[g]),
				.in_status(input_status_reg),
				.bus_word(FIELDBUS_WORD),
				.bit_out(jog_bits[g])
			);
		end
	endgenerate

	assign fixed_out_dummy = sel;

	// panel jog needs no routing, other sources must be configured first
	logic jog0;
	logic jog1;
	assign jog0 = jog_bits[0] | PANEL_JOG0;
	assign jog1 = jog_bits[1] | PANEL_JOG1;
	assign jog_req = jog0 | jog1;

	always_comb begin
		direct_sum = '0;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				direct_sum = direct_sum + widen(sif.first[i]);
			end
		end
	end

	always_comb begin
		fixed_next = '0;
		if (fixed_select_mode_reg == MODE_DIRECT) begin
			fixed_next = direct_sum;
		end else if (sel != 4'h0) begin
			fixed_next = widen(sif.rd_data);
		end
	end

	// jog bit 0 has priority when both are held
	always_comb begin
		if (jog0) begin
			jog_speed_next = widen(jog_speed_one_reg);
		end else begin
			jog_speed_next = widen(jog_speed_two_reg);
		end
	end

	always_comb begin
		jog_next = jog_reg;
		unique case (jog_reg)
			JOG_IDLE: begin
				// a command already held when the motor stops does not start a jog
				if (jog_req && !jog_req_reg && !MOTOR_RUN) begin
					jog_next = JOG_RUN;
				end
			end
			JOG_RUN: begin
				if (!jog_req) begin
					jog_next = JOG_IDLE;
				end
			end
			default: jog_next = JOG_IDLE;
		endcase
	end

	always_comb begin
		speed_next = '0;
		if (jog_next == JOG_RUN) begin
			speed_next = jog_speed_next;
		end else if (main_setpoint_source_reg == MAIN_SRC_FIXED) begin
			speed_next = fixed_next;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			jog_reg <= JOG_IDLE;
			jog_req_reg <= 1'b0;
		end else begin
			jog_reg <= jog_next;
			jog_req_reg <= jog_req;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			FIXED_SETPOINT_OUT <= '0;
			SPEED_SETPOINT <= '0;
			MAIN_FROM_FIXED <= 1'b0;
			JOG_MOTOR_ON <= 1'b0;
			JOG_ACTIVE_BITS <= 2'b00;
			SELECT_ACTIVE <= 4'h0;
			DIGITAL_INPUT_STATUS <= 16'h0000;
		end else begin
			FIXED_SETPOINT_OUT <= fixed_next;
			SPEED_SETPOINT <= speed_next;
			MAIN_FROM_FIXED <= (main_setpoint_source_reg == MAIN_SRC_FIXED);
			JOG_MOTOR_ON <= (jog_next == JOG_RUN);
			JOG_ACTIVE_BITS <= {jog1, jog0};
			SELECT_ACTIVE <= fixed_out_dummy;
			DIGITAL_INPUT_STATUS <= input_status_reg;
		end
	end

	sequence s_jog_issue;
		jog_reg == JOG_IDLE && jog_req && !jog_req_reg;
	endsequence

	sequence s_motor_off;
		!MOTOR_RUN;
	endsequence

	a_src_four_locked: assert property (
		@(posedge CLK) disable iff (!RESET_N) src_reg[3] == SRC_ZERO |-> !sel[3])
		else $error("setpoint four selected with locked source");

	a_direct_sum_out: assert property (
		@(posedge CLK) disable iff (!RESET_N)
		fixed_select_mode_reg == MODE_DIRECT |=> FIXED_SETPOINT_OUT == $past(direct_sum))
		else $error("direct output is not the sum of selected setpoints");

	a_direct_idle_zero: assert property (
		@(posedge CLK) disable iff (!RESET_N)
		fixed_select_mode_reg == MODE_DIRECT && sel == 4'h0 |=> FIXED_SETPOINT_OUT == '0)
		else $error("direct output not zero with nothing selected");

	a_binary_pick_one: assert property (
		@(posedge CLK) disable iff (!RESET_N)
		fixed_select_mode_reg == MODE_BINARY && sel != 4'h0
		|=> FIXED_SETPOINT_OUT == widen($past(sif.rd_data)))
		else $error("binary output is not the selected setpoint");

	a_main_route_fixed: assert property (
		@(posedge CLK) disable iff (!RESET_N)
		main_setpoint_source_reg == MAIN_SRC_FIXED && jog_next == JOG_IDLE
		|=> MAIN_FROM_FIXED && SPEED_SETPOINT == FIXED_SETPOINT_OUT)
		else $error("main setpoint not routed from fixed output");

	a_jog_when_on: assert property (
		@(posedge CLK) disable iff (!RESET_N)
		jog_reg == JOG_IDLE && MOTOR_RUN |=> !JOG_MOTOR_ON)
		else $error("jog started while motor switched on");

	a_jog_start_off: assert property (
		@(posedge CLK) disable iff (!RESET_N)
		s_jog_issue ##0 s_motor_off |=> JOG_MOTOR_ON ##0 jog_reg == JOG_RUN)
		else $error("jog issued with motor off did not start");

	a_jog_release: assert property (
		@(posedge CLK) disable iff (!RESET_N)
		JOG_MOTOR_ON && !jog_req |=> !JOG_MOTOR_ON ##1 !JOG_MOTOR_ON || jog_req_reg)
		else $error("jog did not stop on release");

	a_jog_bit0_wins: assert property (
		@(posedge CLK) disable iff (!RESET_N)
		jog_next == JOG_RUN && jog0 |=> SPEED_SETPOINT == widen($past(jog_speed_one_reg)))
		else $error("jog speed not taken from jog bit 0");

	a_jog_speed_two: assert property (
		@(posedge CLK) disable iff (!RESET_N)
		jog_next == JOG_RUN && !jog0 |=> SPEED_SETPOINT == widen($past(jog_speed_two_reg)))
		else $error("jog speed not taken from jog bit 1");

	a_jog_src_locked: assert property (
		@(posedge CLK) disable iff (!RESET_N)
		jog_src_reg[0] == SRC_ZERO && jog_src_reg[1] == SRC_ZERO |-> jog_bits == 2'b00)
		else $error("jog bit active from a zero source");

	a_panel_jog_taken: assert property (
		@(posedge CLK) disable iff (!RESET_N)
		PANEL_JOG0 || PANEL_JOG1
		|=> (JOG_ACTIVE_BITS & $past({PANEL_JOG1, PANEL_JOG0})) == $past({PANEL_JOG1, PANEL_JOG0}))
		else $error("panel jog bit not accepted");

	a_binary_code_zero: assert property (
		@(posedge CLK) disable iff (!RESET_N)
		fixed_select_mode_reg != MODE_DIRECT && sel == 4'h0 |=> FIXED_SETPOINT_OUT == '0)
		else $error("binary code zero did not give zero output");

	a_main_unrouted: assert property (
		@(posedge CLK) disable iff (!RESET_N)
		main_setpoint_source_reg != MAIN_SRC_FIXED && jog_next == JOG_IDLE
		|=> !MAIN_FROM_FIXED && SPEED_SETPOINT == '0)
		else $error("main setpoint driven while not routed");

	// reset checks carry no disable, they watch the reset itself
	a_reset_table_zero: assert property (
		@(posedge CLK) !RESET_N |=> sif.first[0] == SP_RESET && sif.first[1] == SP_RESET
		&& sif.first[2] == SP_RESET && sif.first[3] == SP_RESET)
		else $error("setpoint table not cleared by reset");

	a_reset_defaults: assert property (
		@(posedge CLK) !RESET_N |=> fixed_select_mode_reg == MODE_DIRECT
		&& jog_speed_one_reg == JOG_SPEED_RESET && jog_speed_two_reg == JOG_SPEED_RESET)
		else $error("mode or jog speeds not at reset defaults");
endmodule
`default_nettype wire

/* design/fss_setpoint_store.sv */
// table of programmable fixed setpoints
`timescale 1ns/1ps
`default_nettype none
module fss_setpoint_store import fss_pkg::*; #(
	parameter int DEPTH = SP_COUNT
) (
	input wire logic clk,
	input wire logic reset_n,
	fss_store_if.store sif
);
	fss_speed_t table_reg [DEPTH];

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				table_reg[i] <= SP_RESET;
			end
		end else if (sif.wr_en) begin
			table_reg[sif.wr_idx] <= sif.wr_data;
		end
	end

	assign sif.rd_data = table_reg[sif.rd_idx];

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_first
			assign sif.first[g] = table_reg[g];
		end
	endgenerate
endmodule
`default_nettype wire

/* design/fss_source_mux.sv */
// picks one selection bit by its configured source code
`timescale 1ns/1ps
`default_nettype none
module fss_source_mux import fss_pkg::*; (
	input wire fss_src_t src,
	input wire logic [15:0] in_status,
	input wire logic [15:0] bus_word,
	output logic bit_out
);
	always_comb begin
		bit_out = 1'b0;
		if (src == SRC_ONE) begin
			bit_out = 1'b1;
		end else if (src[7:4] == SRC_INPUT_BASE[7:4]) begin
			bit_out = in_status[src[3:0]];
		end else if (src[7:4] == SRC_BUS_BASE[7:4]) begin
			bit_out = bus_word[src[3:0]];
		end
	end
endmodule
`default_nettype wire

/* design/fss_store_if.sv */
// link between the selector and its setpoint table
`timescale 1ns/1ps
`default_nettype none
interface fss_store_if;
	import fss_pkg::*;
	logic wr_en;
	logic [3:0] wr_idx;
	fss_speed_t wr_data;
	logic [3:0] rd_idx;
	fss_speed_t rd_data;
	fss_speed_t first [4];
	modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data, output first);
	modport user (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data, input first);
endinterface
`default_nettype wire

/* tb/fss_input_model.sv */
// model of the input side: terminals, operator panel, fieldbus master and motor state
`timescale 1ns/1ps
`default_nettype none
module fss_input_model (
	input wire logic clk,
	output var logic [15:0] pins,
	output var logic [15:0] bus_word,
	output var logic panel_jog0,
	output var logic panel_jog1,
	output var logic motor_run
);
	initial begin
		pins = 16'h0000;
		bus_word = 16'h0000;
		panel_jog0 = 1'b0;
		panel_jog1 = 1'b0;
		motor_run = 1'b0;
	end
	// levels only, all changed just after an edge
	task automatic set_pins(input logic [15:0] v);
		@(posedge clk);
		pins <= v;
	endtask
	// a central controller picks setpoints by code, so the bus word carries binary codes
	task automatic set_bus(input logic [15:0] v);
		@(posedge clk);
		bus_word <= v;
	endtask
	task automatic set_panel(input logic j0, input logic j1);
		@(posedge clk);
		panel_jog0 <= j0;
		panel_jog1 <= j1;
	endtask
	task automatic set_motor(input logic m);
		@(posedge clk);
		motor_run <= m;
	endtask
endmodule
`default_nettype wire

/* tb/fss_setpoint_select_tb.sv */
// self-checking bench of the fixed speed and jog setpoint selector
`timescale 1ns/1ps
`default_nettype none
module fss_setpoint_select_tb import fss_pkg::*;;
	logic CLK = 1'b0;
	logic RESET_N = 1'b0;
	logic CFG_WR_EN = 1'b0;
	logic [3:0] CFG_WR_SEL = 4'h0;
	logic [CFG_W-1:0] CFG_WR_DATA = 16'h0000;
	logic SP_WR_EN = 1'b0;
	logic [3:0] SP_WR_IDX = 4'h0;
	fss_speed_t SP_WR_DATA = 16'h0000;
	wire logic [15:0] pins, bus;
	wire logic pj0, pj1, mrun;
	logic [15:0] DIGITAL_INPUT_STATUS;
	logic [3:0] SELECT_ACTIVE;
	fss_sum_t FIXED_SETPOINT_OUT, SPEED_SETPOINT;
	logic MAIN_FROM_FIXED, JOG_MOTOR_ON;
	logic [1:0] JOG_ACTIVE_BITS;
	int error_cnt = 0;
	int total_checks = 0;
	int cycles = 0;
	fss_speed_t sp [4] = '{16'sd300, 16'sd2000, -16'sd50, 16'sd7};

	always #25 CLK = ~CLK;

	fss_input_model i_src (.clk(CLK), .pins(pins), .bus_word(bus), .panel_jog0(pj0), .panel_jog1(pj1), .motor_run(mrun));

	fss_setpoint_select i_dut (.CLK(CLK), .RESET_N(RESET_N), .DIGITAL_INPUT(pins), .FIELDBUS_WORD(bus),
		.PANEL_JOG0(pj0), .PANEL_JOG1(pj1), .MOTOR_RUN(mrun), .CFG_WR_EN(CFG_WR_EN), .CFG_WR_SEL(CFG_WR_SEL),
		.CFG_WR_DATA(CFG_WR_DATA), .SP_WR_EN(SP_WR_EN), .SP_WR_IDX(SP_WR_IDX), .SP_WR_DATA(SP_WR_DATA),
		.DIGITAL_INPUT_STATUS(DIGITAL_INPUT_STATUS), .SELECT_ACTIVE(SELECT_ACTIVE),
		.FIXED_SETPOINT_OUT(FIXED_SETPOINT_OUT), .SPEED_SETPOINT(SPEED_SETPOINT),
		.MAIN_FROM_FIXED(MAIN_FROM_FIXED), .JOG_MOTOR_ON(JOG_MOTOR_ON), .JOG_ACTIVE_BITS(JOG_ACTIVE_BITS));

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// whole run needs well under a thousand cycles
	always @(posedge CLK) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			error_cnt = error_cnt + 1;
			summarize();
		end
	end

	task automatic chk(input string name, input logic [19:0] seen, input logic [19:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// lets the edge's updates land before sampling
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask

	task automatic cfg(input logic [3:0] sel, input logic [15:0] data);
		@(posedge CLK);
		CFG_WR_EN <= 1'b1;
		CFG_WR_SEL <= sel;
		CFG_WR_DATA <= data;
		@(posedge CLK);
		CFG_WR_EN <= 1'b0;
	endtask

	task automatic sp_wr(input logic [3:0] idx, input fss_speed_t data);
		@(posedge CLK);
		SP_WR_EN <= 1'b1;
		SP_WR_IDX <= idx;
		SP_WR_DATA <= data;
		@(posedge CLK);
		SP_WR_EN <= 1'b0;
	endtask

	// setpoints first, so an unrouted main setpoint is seen against a non-zero fixed output
	task automatic test_main_route();
		fss_sum_t exp;
		exp = fss_sum_t'(sp[0]) + fss_sum_t'(sp[1]) + fss_sum_t'(sp[2]);
		for (int i = 0; i < 4; i++) sp_wr(4'(i), sp[i]);
		cyc(2);
		chk("fixed_out", FIXED_SETPOINT_OUT, exp);
		chk("speed_unrouted", SPEED_SETPOINT, 20'h00000);
		cfg(CFG_MAIN_SRC, MAIN_SRC_FIXED);
		cyc(2);
		chk("main_fixed", 20'(MAIN_FROM_FIXED), 20'h00001);
		chk("speed_routed", SPEED_SETPOINT, exp);
		$display("main routing done");
	endtask

	task automatic test_reset();
		i_src.set_pins(16'h0038);
		cyc(4);
		chk("fixed_out", FIXED_SETPOINT_OUT, 20'h00000);
		chk("select", 20'(SELECT_ACTIVE), 20'h00007);
		chk("main_fixed", 20'(MAIN_FROM_FIXED), 20'h00000);
		chk("speed", SPEED_SETPOINT, 20'h00000);
		$display("reset defaults done");
	endtask

	// walks digital inputs 3 to 6 through all sixteen patterns
	task automatic test_direct(input logic four);
		fss_sum_t exp;
		for (int m = 0; m < 16; m++) begin
			i_src.set_pins(16'(m) << 3);
			cyc(3);
			exp = '0;
			for (int i = 0; i < 4; i++) begin
				if (m[i] && (i < 3 || four)) exp += fss_sum_t'(sp[i]);
			end
			chk("fixed_out", FIXED_SETPOINT_OUT, exp);
			chk("speed", SPEED_SETPOINT, exp);
			chk("select", 20'(SELECT_ACTIVE), 20'(four ? m : (m & 7)));
			chk("input_status", 20'(DIGITAL_INPUT_STATUS), 20'(m << 3));
		end
		$display("direct selection done");
	endtask

	task automatic test_binary();
		fss_sum_t exp;
		cfg(CFG_MODE, 16'h0002);
		for (int i = 0; i < 4; i++) cfg(4'(i), 16'(SRC_BUS_BASE) + 16'(i));
		for (int k = 0; k < 15; k++) sp_wr(4'(k), fss_speed_t'(k * 37 - 200));
		for (int c = 15; c >= 0; c--) begin
			i_src.set_bus(16'(c));
			cyc(3);
			exp = (c == 0) ? '0 : fss_sum_t'(fss_speed_t'((c - 1) * 37 - 200));
			chk("bin_out", FIXED_SETPOINT_OUT, exp);
			chk("bin_sel", 20'(SELECT_ACTIVE), 20'(c));
		end
		// mode 1 turns the same bus bits back into a sum of entries 0 and 1
		cfg(CFG_MODE, 16'h0001);
		i_src.set_bus(16'h0003);
		cyc(3);
		exp = fss_sum_t'((0 * 37 - 200) + (1 * 37 - 200));
		chk("direct_again", FIXED_SETPOINT_OUT, exp);
		$display("binary selection done");
	endtask

	task automatic test_jog();
		i_src.set_motor(1'b1);
		i_src.set_panel(1'b1, 1'b0);
		cyc(3);
		chk("jog_refused", 20'(JOG_MOTOR_ON), 20'h0);
		i_src.set_motor(1'b0);
		cyc(3);
		chk("jog_held", 20'(JOG_MOTOR_ON), 20'h0);
		i_src.set_panel(1'b0, 1'b0);
		i_src.set_panel(1'b1, 1'b0);
		cyc(3);
		chk("jog_on", 20'(JOG_MOTOR_ON), 20'h1);
		chk("jog_bits", 20'(JOG_ACTIVE_BITS), 20'h1);
		chk("jog_speed", SPEED_SETPOINT, 20'h00096);
		i_src.set_panel(1'b0, 1'b1);
		cyc(3);
		chk("jog_bits_two", 20'(JOG_ACTIVE_BITS), 20'h2);
		chk("jog_two_reset", SPEED_SETPOINT, 20'h00096);
		cfg(CFG_JOG_SPEED_TWO, 16'hFF38);
		i_src.set_panel(1'b1, 1'b1);
		cyc(3);
		chk("jog_both", SPEED_SETPOINT, 20'h00096);
		i_src.set_panel(1'b0, 1'b1);
		cyc(3);
		chk("jog_two", SPEED_SETPOINT, 20'hFFF38);
		i_src.set_panel(1'b0, 1'b0);
		cyc(3);
		chk("jog_off", 20'(JOG_MOTOR_ON), 20'h0);
		// an unrouted input must not jog
		i_src.set_pins(16'h0080);
		cyc(3);
		chk("jog_unrouted", 20'(JOG_MOTOR_ON), 20'h0);
		cfg(CFG_JOG0_SRC, 16'h0017);
		cyc(3);
		chk("jog_di", 20'(JOG_MOTOR_ON), 20'h1);
		i_src.set_pins(16'h0000);
		cyc(3);
		chk("jog_di_off", 20'(JOG_MOTOR_ON), 20'h0);
		$display("jog done");
	endtask

	initial begin
		repeat (6) @(posedge CLK);
		RESET_N <= 1'b1;
		test_reset();
		test_main_route();
		test_direct(1'b0);
		cfg(CFG_SRC_FOUR, 16'h0016);
		test_direct(1'b1);
		test_binary();
		test_jog();
		summarize();
	end
endmodule
`default_nettype wire
